// File: logic/flash_status_hold_protect.sv
// Status register, write guard and pause logic of a serial flash
`timescale 1ns/100ps
`include "fshp_map.svh"
`default_nettype none
module flash_status_hold_protect
    import fshp_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    input wire logic busy_i,
    input wire logic auto_inc_mode_i,
    input wire logic op_done_i,
    input wire logic auto_inc_end_i,
    input wire logic req_valid_i,
    input wire logic req_chip_i,
    input wire logic [`FSHP_ADDR_W-1:0] req_addr_i,
    output logic req_allow_o,
    output logic write_latch_flag_o,
    output logic [3:0] prot_level_o,
    output logic prot_lockdown_o,
    output logic paused_o
);

    // Protected region test for one array address
    function automatic logic prot_hit(input logic [2:0] lvl, input logic [`FSHP_ADDR_W-1:0] addr);
        logic [`FSHP_ADDR_W-1:0] top;
        logic [`FSHP_ADDR_W-1:0] ones;
        logic [2:0] k;
        top = '0;
        ones = '0;
        k = 3'd0;
        if (lvl == 3'd0) begin
            prot_hit = 1'b0;
        end else if (lvl >= 3'd6) begin
            prot_hit = 1'b1;
        end else begin
            k = 3'd6 - lvl;
            top = addr >> (`FSHP_ADDR_W - 32'(k));
            ones = (`FSHP_ADDR_W'(1) << k) - `FSHP_ADDR_W'(1);
            prot_hit = (top == ones);
        end
    endfunction

    logic [1:0] rst_sync;
    logic rst_n;
    fshp_state_t r;
    fshp_state_t n;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic paused;
    logic [7:0] byte_in;
    logic [7:0] status_now;
    logic wr_allowed;

    fshp_hold_if hif ();

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Pause controller
    assign hif.sel = ~r.cs_s;
    assign hif.sck_low = ~r.sck_s;
    assign hif.hold_n = r.hold_s;
    assign paused = hif.paused;

    fshp_hold u_hold (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .hif(hif)
    );

    // Edge detection on synchronised pins
    assign sck_rise = r.sck_s & ~r.sck_d;
    assign sck_fall = ~r.sck_s & r.sck_d;
    assign cs_rise = r.cs_s & ~r.cs_d;
    assign byte_in = {r.shreg[6:0], r.si_s};

    // Live status word
    always_comb begin
        status_now = 8'h00;
        status_now[`FSHP_BUSY_BIT] = busy_i;
        status_now[`FSHP_WL_BIT] = r.wl;
        status_now[`FSHP_PL_MSB:`FSHP_PL_LSB] = r.prot;
        status_now[`FSHP_AUTO_INC_BIT] = auto_inc_mode_i;
        status_now[`FSHP_LOCK_BIT] = r.lock;
    end

    // Guard pin and lockdown decide status writes
    assign wr_allowed = r.wp_s | ~r.lock;

    // Next state
    always_comb begin
        n = r;
        n.sck_m = sck_i;
        n.sck_s = r.sck_m;
        n.sck_d = r.sck_s;
        n.cs_m = cs_n_i;
        n.cs_s = r.cs_m;
        n.cs_d = r.cs_s;
        n.si_m = si_i;
        n.si_s = r.si_m;
        n.hold_m = hold_n_i;
        n.hold_s = r.hold_m;
        n.wp_m = wp_n_i;
        n.wp_s = r.wp_m;

        // Engine events clear the latch first
        if (op_done_i || auto_inc_end_i) begin
            n.wl = 1'b0;
        end

        if (r.cs_s) begin
            // Command runs on deselect after whole bytes only
            if (cs_rise && r.cmd_ok && !paused) begin
                unique case (r.opcode)
                    `FSHP_OP_WRITE_DISABLE: n.wl = 1'b0;
                    `FSHP_OP_WRITE_ALLOW: n.wl = 1'b1;
                    `FSHP_OP_STATUS_WRITE: begin
                        n.wl = 1'b0;
                        if (r.wl && wr_allowed) begin
                            n.prot = r.wr_data[`FSHP_PL_MSB:`FSHP_PL_LSB];
                            n.lock = r.wr_data[`FSHP_LOCK_BIT];
                        end
                    end
                    default: n.cmd_ok = 1'b0;
                endcase
            end
            // Deselect resets the serial logic
            n.phase = FSHP_PH_OPC;
            n.bit_cnt = 3'd0;
            n.out_cnt = 3'd0;
            n.cmd_ok = 1'b0;
            n.so_oe = 1'b0;
        end else if (!paused) begin
            // Input shift on rising clock, frozen while paused
            if (sck_rise) begin
                n.shreg = byte_in;
                n.bit_cnt = r.bit_cnt + 3'd1;
                if (r.phase == FSHP_PH_SKIP) begin
                    n.cmd_ok = 1'b0;
                end
                if (r.bit_cnt == 3'd7) begin
                    unique case (r.phase)
                        FSHP_PH_OPC: begin
                            n.opcode = byte_in;
                            n.phase = FSHP_PH_SKIP;
                            if (byte_in == `FSHP_OP_RDSR) begin
                                n.phase = FSHP_PH_RDOUT;
                                n.rd_shift = status_now;
                                n.out_cnt = 3'd0;
                            end else if (!busy_i && byte_in == `FSHP_OP_STATUS_WRITE) begin
                                n.phase = FSHP_PH_WRDATA;
                            end else if (!busy_i) begin
                                n.cmd_ok = (byte_in == `FSHP_OP_WRITE_ALLOW) || (byte_in == `FSHP_OP_WRITE_DISABLE);
                            end
                        end
                        FSHP_PH_WRDATA: begin
                            n.wr_data = byte_in;
                            n.cmd_ok = 1'b1;
                            n.phase = FSHP_PH_SKIP;
                        end
                        FSHP_PH_RDOUT: n.phase = FSHP_PH_RDOUT;
                        FSHP_PH_SKIP: n.phase = FSHP_PH_SKIP;
                    endcase
                end
            end
            // Status bits out on falling clock, repeated
            if (sck_fall && r.phase == FSHP_PH_RDOUT) begin
                n.so = r.rd_shift[7];
                n.so_oe = 1'b1;
                n.out_cnt = r.out_cnt + 3'd1;
                if (r.out_cnt == 3'd7) begin
                    n.rd_shift = status_now;
                end else begin
                    n.rd_shift = {r.rd_shift[6:0], 1'b0};
                end
            end
        end
    end

    // State register with power-up values
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.sck_m <= 1'b0;
            r.cs_m <= 1'b1;
            r.cs_s <= 1'b1;
            r.cs_d <= 1'b1;
            r.hold_m <= 1'b1;
            r.hold_s <= 1'b1;
            r.wp_m <= 1'b1;
            r.wp_s <= 1'b1;
            r.phase <= FSHP_PH_OPC;
            r.wl <= `FSHP_WL_RST;
            r.prot <= `FSHP_PL_RST;
            r.lock <= `FSHP_LOCK_RST;
        end else begin
            r <= n;
        end
    end

    // Program and erase permission for the array engine
    always_comb begin
        req_allow_o = 1'b0;
        if (req_valid_i && r.wl && !busy_i) begin
            if (req_chip_i) begin
                req_allow_o = (r.prot == 4'h0);
            end else begin
                req_allow_o = ~prot_hit(r.prot[2:0], req_addr_i);
            end
        end
    end

    // Pin and status outputs
    assign so_o = r.so;
    assign so_oe_o = r.so_oe & ~paused;
    assign write_latch_flag_o = r.wl;
    assign prot_level_o = r.prot;
    assign prot_lockdown_o = r.lock;
    assign paused_o = paused;

    // Output floats and holds its bit during pause
    pause_float_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        paused && $past(paused) |-> !so_oe_o && $stable(so_o))
        else $error("output driven while paused");

    // Status write refused by lockdown with guard pin low keeps protection
    status_refuse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cs_rise && r.cmd_ok && !paused && r.opcode == `FSHP_OP_STATUS_WRITE && !r.wp_s && r.lock
        |=> $stable(prot_level_o) && prot_lockdown_o)
        else $error("locked status write changed protection");

    // Status write always clears latch
    status_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cs_rise && r.cmd_ok && !paused && r.opcode == `FSHP_OP_STATUS_WRITE |=> !write_latch_flag_o)
        else $error("latch survived a status write");

    // Allowed status write loads the levels
    status_load_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        cs_rise && r.cmd_ok && !paused && r.opcode == `FSHP_OP_STATUS_WRITE && r.wl && (r.wp_s || !r.lock)
        |=> prot_level_o == $past(r.wr_data[5:2]))
        else $error("allowed status write not applied");

    // No latch, no program or erase
    latch_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        !write_latch_flag_o |-> !req_allow_o)
        else $error("write allowed without latch");

    // Chip erase needs zero levels
    chip_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        req_chip_i && prot_level_o != 4'h0 |-> !req_allow_o)
        else $error("chip erase allowed while protected");

    // Top levels protect every address
    all_blocks_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        prot_level_o[2:1] == 2'b11 |-> !req_allow_o)
        else $error("write allowed into a protected region");

    // Power-up values
    powerup_vals_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        $rose(rst_n) |-> prot_level_o == 4'h7 && !write_latch_flag_o && !prot_lockdown_o)
        else $error("wrong power-up status");

    // Input frozen while paused
    pause_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        paused && !r.cs_s |=> $stable(r.shreg) && $stable(r.bit_cnt))
        else $error("serial state moved while paused");

endmodule
`default_nettype wire

// File: logic/fshp_hold.sv
// Pause controller driven by the pause pin and the serial clock level
`timescale 1ns/100ps
`default_nettype none
module fshp_hold
    import fshp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    fshp_hold_if.ctl hif
);

    fshp_hold_state_t r;
    fshp_hold_state_t n;

    // While selected, pause entry and exit only with the clock low; deselect with the pin high ends the pause
    always_comb begin
        n = r;
        if (hif.sel) begin
            if (hif.sck_low) begin
                n.paused = ~hif.hold_n;
            end
        end else if (hif.hold_n) begin
            n.paused = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign hif.paused = r.paused;

    // Pause entry at a low clock
    pause_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hif.sel && hif.sck_low && !hif.hold_n |=> hif.paused)
        else $error("pause not entered with clock low");

    // Pause exit at a low clock
    pause_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hif.sel && hif.sck_low && hif.hold_n |=> !hif.paused)
        else $error("pause not left with clock low");

    // Edges with clock high are deferred
    pause_defer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        hif.sel && !hif.sck_low |=> hif.paused == $past(hif.paused))
        else $error("pause changed while clock high");

    // Deselect keeps the pause while the pin stays low
    pause_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !hif.sel && !hif.hold_n && hif.paused |=> hif.paused)
        else $error("pause dropped on deselect with pin low");

endmodule
`default_nettype wire

// File: logic/fshp_hold_if.sv
// Signals between the serial core and the pause controller
`timescale 1ns/100ps
`default_nettype none
interface fshp_hold_if;
    logic sel;
    logic sck_low;
    logic hold_n;
    logic paused;

    modport ctl (input sel, input sck_low, input hold_n, output paused);
    modport core (output sel, output sck_low, output hold_n, input paused);
endinterface
`default_nettype wire

// File: logic/fshp_map.svh
// Field positions, reset values, opcodes and address width of the flash status block
`ifndef FSHP_MAP_SVH
`define FSHP_MAP_SVH

// Status register field positions
`define FSHP_BUSY_BIT 0
`define FSHP_WL_BIT 1
`define FSHP_PL_LSB 2
`define FSHP_PL_MSB 5
`define FSHP_AUTO_INC_BIT 6
`define FSHP_LOCK_BIT 7

// Power-up values
`define FSHP_PL_RST 4'h7
`define FSHP_WL_RST 1'b0
`define FSHP_LOCK_RST 1'b0

// Serial opcodes handled here
`define FSHP_OP_STATUS_WRITE 8'h01
`define FSHP_OP_WRITE_DISABLE 8'h04
`define FSHP_OP_RDSR 8'h05
`define FSHP_OP_WRITE_ALLOW 8'h06

// Array address width
`define FSHP_ADDR_W 21

`endif

// File: logic/fshp_pkg.sv
// Types shared by the flash status and hold logic
`default_nettype none
package fshp_pkg;

    // Serial sequence phase
    typedef enum logic [3:0] {
        FSHP_PH_OPC = 4'b0001,
        FSHP_PH_WRDATA = 4'b0010,
        FSHP_PH_RDOUT = 4'b0100,
        FSHP_PH_SKIP = 4'b1000
    } fshp_phase_t;

    // State of the top module apart from the reset synchroniser
    typedef struct packed {
        logic sck_m;
        logic sck_s;
        logic sck_d;
        logic cs_m;
        logic cs_s;
        logic cs_d;
        logic si_m;
        logic si_s;
        logic hold_m;
        logic hold_s;
        logic wp_m;
        logic wp_s;
        fshp_phase_t phase;
        logic [2:0] bit_cnt;
        logic [2:0] out_cnt;
        logic [7:0] shreg;
        logic [7:0] opcode;
        logic [7:0] wr_data;
        logic [7:0] rd_shift;
        logic cmd_ok;
        logic so;
        logic so_oe;
        logic wl;
        logic [3:0] prot;
        logic lock;
    } fshp_state_t;

    // State of the pause controller
    typedef struct packed {
        logic paused;
    } fshp_hold_state_t;

endpackage
`default_nettype wire

// File: verification/fshp_host_model.sv
// Behavioural SPI host driving select, serial clock, pause and guard pins
`timescale 1ns/100ps
`include "fshp_map.svh"
`default_nettype none
module fshp_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    output logic wp_n_o
);
    // Idle pins: mode 0 clock low, deselected, guard high
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        wp_n_o = 1'b1;
    end

    // Half a serial clock period, 80 ns
    task automatic half();
        repeat (16) @(negedge clk_i);
    endtask

    // Drive one pin: 0 clock, 1 select, 2 pause, 3 guard
    task automatic pin(input int which, input logic v);
        case (which)
            0: sck_o = v;
            1: cs_n_o = v;
            2: hold_n_o = v;
            default: wp_n_o = v;
        endcase
        half();
    endtask

    // One byte MSB first; an undriven output reads unknown
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            half();
            sck_o = 1'b1;
            rx[i] = so_oe_i ? so_i : 1'bx;
            half();
            sck_o = 1'b0;
        end
    endtask

    // Framed command with optional data byte
    task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic two);
        logic [7:0] rx;
        pin(1, 1'b0);
        xfer(op, rx);
        if (two) begin
            xfer(dat, rx);
        end
        si_o = ~si_o; // Released data line shows no stale value
        pin(1, 1'b1);
    endtask

    // Status read: opcode then one status byte
    task automatic rdsr(output logic [7:0] st);
        logic [7:0] rx;
        pin(1, 1'b0);
        xfer(`FSHP_OP_RDSR, rx);
        xfer(8'h5a, st);
        si_o = ~si_o;
        pin(1, 1'b1);
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench of the flash status, guard and pause block
`timescale 1ns/100ps
`include "fshp_map.svh"
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
    localparam int SCK = 0;
    localparam int SEL = 1;
    localparam int HOLD = 2;
    localparam int GUARD = 3;
    logic clk, arst_n, sck, cs_n, si, hold_n, wp_n, so, so_oe;
    logic busy, auto_inc_mode, op_done, auto_inc_end, req_valid, req_chip, req_allow;
    logic [`FSHP_ADDR_W-1:0] req_addr;
    logic wl, lock, paused;
    logic [3:0] prot;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;

    flash_status_hold_protect flash_status_hold_protect_i (
        .clk_i(clk),
        .arst_n_i(arst_n),
        .sck_i(sck),
        .cs_n_i(cs_n),
        .si_i(si),
        .hold_n_i(hold_n),
        .wp_n_i(wp_n),
        .so_o(so),
        .so_oe_o(so_oe),
        .busy_i(busy),
        .auto_inc_mode_i(auto_inc_mode),
        .op_done_i(op_done),
        .auto_inc_end_i(auto_inc_end),
        .req_valid_i(req_valid),
        .req_chip_i(req_chip),
        .req_addr_i(req_addr),
        .req_allow_o(req_allow),
        .write_latch_flag_o(wl),
        .prot_level_o(prot),
        .prot_lockdown_o(lock),
        .paused_o(paused)
    );

    fshp_host_model fshp_host_model_i (
        .clk_i(clk),
        .so_i(so),
        .so_oe_i(so_oe),
        .sck_o(sck),
        .cs_n_o(cs_n),
        .si_o(si),
        .hold_n_o(hold_n),
        .wp_n_o(wp_n)
    );

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            summarize();
        end
    end

    // Read status, compare it and the mirrored outputs
    task automatic st(input logic [7:0] e);
        logic [7:0] rx;
        fshp_host_model_i.rdsr(rx);
        `CHK(rx, e)
        `CHK({lock, prot, wl}, {e[7], e[5:2], e[1]})
    endtask

    // Program or erase permission, answered in the same cycle
    task automatic req(input logic chip, input logic [`FSHP_ADDR_W-1:0] a, input logic e);
        req_valid = 1'b1;
        req_chip = chip;
        req_addr = a;
        #1;
        `CHK(req_allow, e)
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
    endtask

    // Write-allow then status write in separate frames
    task automatic wr(input logic [7:0] d);
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_ALLOW, 8'h00, 1'b0);
        fshp_host_model_i.cmd(`FSHP_OP_STATUS_WRITE, d, 1'b1);
    endtask

    // Main sequence
    initial begin
        logic [7:0] rx;
        {busy, auto_inc_mode, op_done, auto_inc_end, req_valid, req_chip} = 6'h00;
        req_addr = '0;
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
        `CHK(paused, 1'b0)
        st(8'h1c);
        req(1'b0, 21'h000000, 1'b0);
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_ALLOW, 8'h00, 1'b0);
        st(8'h1e);
        req(1'b1, 21'h000000, 1'b0);
        req(1'b0, 21'h000000, 1'b0);
        fshp_host_model_i.cmd(`FSHP_OP_STATUS_WRITE, 8'h00, 1'b1);
        st(8'h00);
        // Busy engine: only status polling meanwhile
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_ALLOW, 8'h00, 1'b0);
        busy = 1'b1;
        auto_inc_mode = 1'b1;
        st(8'h43);
        req(1'b1, 21'h000000, 1'b0);
        busy = 1'b0;
        auto_inc_mode = 1'b0;
        req(1'b1, 21'h000000, 1'b1);
        op_done = 1'b1;
        @(negedge clk);
        op_done = 1'b0;
        st(8'h00);
        req(1'b0, 21'h000000, 1'b0);
        // Upper thirty-second protected
        wr(8'h04);
        st(8'h04);
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_ALLOW, 8'h00, 1'b0);
        req(1'b0, 21'h1effff, 1'b1);
        req(1'b0, 21'h1f0000, 1'b0);
        req(1'b1, 21'h000000, 1'b0);
        auto_inc_end = 1'b1;
        @(negedge clk);
        auto_inc_end = 1'b0;
        st(8'h04);
        // Lockdown against the guard pin
        wr(8'h80);
        st(8'h80);
        fshp_host_model_i.pin(GUARD, 1'b0);
        wr(8'h1c);
        st(8'h80);
        fshp_host_model_i.pin(GUARD, 1'b1);
        wr(8'h1c);
        st(8'h1c);
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_ALLOW, 8'h00, 1'b0);
        fshp_host_model_i.cmd(`FSHP_OP_WRITE_DISABLE, 8'h00, 1'b0);
        st(8'h1c);
        // Pause in mid-read, with one stray clock while paused
        fshp_host_model_i.pin(SEL, 1'b0);
        fshp_host_model_i.xfer(`FSHP_OP_RDSR, rx);
        fshp_host_model_i.xfer(8'h00, rx);
        `CHK(rx, 8'h1c)
        fshp_host_model_i.pin(HOLD, 1'b0);
        `CHK(paused, 1'b1)
        `CHK(so_oe, 1'b0)
        fshp_host_model_i.pin(SCK, 1'b1);
        fshp_host_model_i.pin(SCK, 1'b0);
        fshp_host_model_i.pin(HOLD, 1'b1);
        `CHK(paused, 1'b0)
        fshp_host_model_i.xfer(8'h00, rx);
        `CHK(rx, 8'h1c)
        // Pause pin falling with the clock high
        fshp_host_model_i.pin(SCK, 1'b1);
        fshp_host_model_i.pin(HOLD, 1'b0);
        `CHK(paused, 1'b0)
        fshp_host_model_i.pin(SCK, 1'b0);
        `CHK(paused, 1'b1)
        fshp_host_model_i.pin(SEL, 1'b1);
        `CHK(paused, 1'b1)
        fshp_host_model_i.pin(HOLD, 1'b1);
        `CHK(paused, 1'b0)
        st(8'h1c);
        summarize();
    end
endmodule
`default_nettype wire
